// ===== shared/spc_pkg.sv
package spc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] SPC_DATA_IDX = 6'h21;
  localparam logic [5:0] SPC_CTRL_IDX = 6'h22;
  localparam logic [5:0] SPC_STAT_IDX = 6'h23;
  localparam logic [7:0] SPC_DATA_ADDR = {SPC_DATA_IDX, 2'b00};
  localparam logic [7:0] SPC_CTRL_ADDR = {SPC_CTRL_IDX, 2'b00};
  localparam logic [7:0] SPC_STAT_ADDR = {SPC_STAT_IDX, 2'b00};

  // Control register fields
  localparam int CTL_IRQ_EN  = 7;
  localparam int CTL_PER_EN  = 6;
  localparam int CTL_HALF    = 5;
  localparam int CTL_MASTER  = 4;
  localparam int CTL_CLOCK_POLARITY_BIT    = 3;
  localparam int CTL_CLOCK_PHASE_BIT    = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;

  // Status register fields
  localparam int STA_DONE  = 7;
  localparam int STA_WRITE_COLLISION_FLAG  = 6;
  localparam int STA_OVR   = 5;
  localparam int STA_MODE_FAULT_FLAG  = 4;
  localparam int STA_RSVD  = 3;
  localparam int STA_ODIS  = 2;
  localparam int STA_SSOFT = 1;
  localparam int STA_SSLVL = 0;

  // Reset values
  localparam logic [7:0] SPC_CTRL_RST = 8'h00;
  localparam logic [2:0] SPC_STLO_RST = 3'h0;

  // Half periods of SCK in core clocks for each divide ratio
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // Sixteen SCK transitions per byte; the last one has index 15
  localparam logic [3:0] LAST_EDGE = 4'hf;

  typedef enum logic [0:0] {SPC_IDLE, SPC_SHIFT} spc_xfer_e;

endpackage

// ===== logic/spc_core.sv
`timescale 1ns/1ps
// How it works
// - One interrupt line, gated by enable and mask
// - Interrupt enable passes done, fault, overrun
// - Peripheral enable; hardware clears on master fault
// - Master select; cleared on master fault
// - Clock polarity sets SCK idle level
// - Clock phase picks first or second capture
// - Master SCK is core clock over 4..128
// - Half divider bit removes divide-by-two stage at rate codes 00 and 10
// - Divider bits ignored in slave mode
// - Done flag cleared by status then data
// - Data writes ignored while done unread
// - Write collision flag, no interrupt
// - Overrun when byte lands on set done
// - Mode fault cleared by status then control
// - Reserved status bit reads zero
// - Output disable removes data output
// - Soft select replaces pin with level bit
// - Level bit zero selects the slave
// - Master data write starts a byte
// - Received byte buffered at done; reads buffer
// - Done wakes from halt, overrun does not
// - Collision cleared by status then data read
// - Colliding write discarded, transfer goes on
// - Overrun keeps first unread byte
module spc_core
  import spc_pkg::*;
(
  input  wire logic        core_clk,        // Core clock, 25 MHz
  input  wire logic        sys_rst,         // Synchronous reset
  input  wire logic [7:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire logic        cpu_irq_mask,    // CPU interrupt mask, 1 masks
  output logic             spi_irq,         // Shared interrupt request
  output logic             halt_wake,       // Wake request from halt
  output logic             pins_alt_en,     // SPI owns its pins
  input  wire logic        sck_in,          // SCK pin level
  output logic             sck_out,         // SCK drive
  output logic             sck_oe,          // SCK enable
  input  wire logic        mosi_in,         // MOSI pin level
  output logic             mosi_out,        // MOSI drive
  output logic             mosi_oe,         // MOSI enable
  input  wire logic        miso_in,         // MISO pin level
  output logic             miso_out,        // MISO drive
  output logic             miso_oe,         // MISO enable
  input  wire logic        ss_n_in          // Slave select pin, active low
);

  typedef struct packed {
    logic [7:0] ctl;       // Control register
    logic       done;      // Transfer done flag
    logic       write_collision_flag;      // Write collision flag
    logic       overrun_flag;       // Overrun flag
    logic       mode_fault_flag;      // Mode fault flag
    logic [2:0] stlo;      // Output disable, soft select, level
    logic       stat_seen; // Status read since done last cleared or set
    logic       mode_fault_flag_seen; // Status access while fault set
    logic [7:0] rxbuf;     // Receive buffer
    logic [7:0] sh;        // Shift register
    logic       dout;      // Serial data out bit
    spc_xfer_e  xfer;      // Master transfer state
    logic [3:0] edge_cnt;  // SCK transition index
    logic [6:0] div_cnt;   // Half period counter
    logic       sck;       // Master SCK level
    logic       sck_prev;  // Previous SCK pin sample
    logic       wreq;      // Waitrequest
    logic [7:0] rdata;     // Read data
    logic       irq;       // Interrupt output
    logic       wake;      // Wake output
    logic [3:0] pins;      // Alt flag, SCK, MOSI and MISO enables
    logic       done_ev;   // Byte completed last cycle
  } spc_state_s;

  spc_state_s st_ff;   // Registered state
  spc_state_s nxt_st;  // Next state

  // Decoded request, taken only in the cycle waitrequest is low
  logic       req;       // Any access pending
  logic       acc;       // Access completes this edge
  logic       wr_data;   // Data register write
  logic       rd_data;   // Data register read
  logic       wr_ctl;    // Control register write
  logic       rd_stat;   // Status register read
  logic       lane0;     // Low byte lane enabled
  logic       master;    // Master mode
  logic       ss_int_n;  // Internal slave select, low selects
  logic       sck_edge;  // One SCK transition this cycle
  logic       capture;   // Transition is a capture edge
  logic       sin;       // Serial input bit for this mode
  logic       busy;      // Transfer sequence in progress
  logic [6:0] half;      // Selected half period
  logic [7:0] stat_rd;   // Status register image

  // Request decode and mode helpers
  always_comb
  begin
    req      = avs_read | avs_write;
    acc      = req & ~st_ff.wreq;
    lane0    = avs_byteenable[0];
    wr_data  = acc & avs_write & lane0 & (avs_address == SPC_DATA_ADDR);
    rd_data  = acc & avs_read & (avs_address == SPC_DATA_ADDR);
    wr_ctl   = acc & avs_write & lane0 & (avs_address == SPC_CTRL_ADDR);
    rd_stat  = acc & avs_read & (avs_address == SPC_STAT_ADDR);
    master   = st_ff.ctl[CTL_MASTER];
    // Pin or software level selects the slave
    ss_int_n = st_ff.stlo[STA_SSOFT] ? st_ff.stlo[STA_SSLVL]
                                     : ss_n_in;
    sin      = master ? miso_in : mosi_in;
    stat_rd  = {st_ff.done, st_ff.write_collision_flag, st_ff.overrun_flag, st_ff.mode_fault_flag,
                1'b0, st_ff.stlo};
    busy     = master ? (st_ff.xfer == SPC_SHIFT)
                      : (st_ff.edge_cnt != 4'h0);
  end

  // Ratio select; only master timing reads it, so slave ignores it
  always_comb
  begin
    case (st_ff.ctl[CTL_RATE_HI:CTL_RATE_LO])
      2'b00:   half = st_ff.ctl[CTL_HALF] ? HALF_DIV4 : HALF_DIV8;
      2'b01:   half = HALF_DIV16;
      2'b10:   half = st_ff.ctl[CTL_HALF] ? HALF_DIV32 : HALF_DIV64;
      default: half = HALF_DIV128;
    endcase
  end

  // Edge timing: master from divider, slave from the SCK pin
  always_comb
  begin
    if (master)
    begin
      sck_edge = (st_ff.xfer == SPC_SHIFT) && (st_ff.div_cnt == 7'h01);
    end
    else
    begin
      sck_edge = st_ff.ctl[CTL_PER_EN] & ~ss_int_n &
                 (sck_in != st_ff.sck_prev);
    end
    // Phase 0 captures on even transitions, phase 1 on odd ones
    capture = (st_ff.edge_cnt[0] == st_ff.ctl[CTL_CLOCK_PHASE_BIT]);
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.sck_prev = sck_in;
    nxt_st.done_ev  = 1'b0;
    nxt_st.wreq     = 1'b1;

    // Bus answer: one stall cycle, then one ready cycle
    if (req && st_ff.wreq)
    begin
      nxt_st.wreq = 1'b0;
      if (avs_address == SPC_DATA_ADDR)
      begin
        nxt_st.rdata = st_ff.rxbuf;
      end
      else if (avs_address == SPC_CTRL_ADDR)
      begin
        nxt_st.rdata = st_ff.ctl;
      end
      else if (avs_address == SPC_STAT_ADDR)
      begin
        nxt_st.rdata = stat_rd;
      end
      else
      begin
        nxt_st.rdata = 8'h00; // Unmapped reads as zero
      end
    end

    // Clearing sequences, applied before hardware sets
    if (rd_stat)
    begin
      nxt_st.overrun_flag       = 1'b0;
      nxt_st.stat_seen = 1'b1;
      nxt_st.mode_fault_flag_seen = st_ff.mode_fault_flag;
    end
    if ((rd_data || wr_data) && st_ff.stat_seen)
    begin
      nxt_st.done      = 1'b0;
      nxt_st.stat_seen = 1'b0;
    end
    if (rd_data && st_ff.stat_seen)
    begin
      nxt_st.write_collision_flag = 1'b0;
    end

    // Control write; fault blocks enabling outside its clear sequence
    if (wr_ctl)
    begin
      nxt_st.ctl = avs_writedata[7:0];
      if (st_ff.mode_fault_flag && st_ff.mode_fault_flag_seen)
      begin
        nxt_st.mode_fault_flag      = 1'b0;
        nxt_st.mode_fault_flag_seen = 1'b0;
      end
      else if (st_ff.mode_fault_flag)
      begin
        nxt_st.ctl[CTL_PER_EN] = 1'b0;
        nxt_st.ctl[CTL_MASTER] = 1'b0;
      end
    end
    // Only the three software bits of status are writable
    if (acc && avs_write && lane0 && (avs_address == SPC_STAT_ADDR))
    begin
      nxt_st.stlo = avs_writedata[2:0];
    end

    // Data write: collision, inhibit, or load
    if (wr_data)
    begin
      if (busy)
      begin
        nxt_st.write_collision_flag = 1'b1;
      end
      else if (st_ff.done && !st_ff.stat_seen)
      begin
        nxt_st.sh = st_ff.sh;
      end
      else
      begin
        nxt_st.sh = avs_writedata[7:0];
        if (!st_ff.ctl[CTL_CLOCK_PHASE_BIT])
        begin
          nxt_st.dout = avs_writedata[7];
        end
        if (master && st_ff.ctl[CTL_PER_EN])
        begin
          nxt_st.xfer     = SPC_SHIFT;
          nxt_st.div_cnt  = half;
          nxt_st.edge_cnt = 4'h0;
          nxt_st.sck      = st_ff.ctl[CTL_CLOCK_POLARITY_BIT];
        end
      end
    end

    // Master divider runs one half period per SCK transition
    if (st_ff.xfer == SPC_SHIFT)
    begin
      nxt_st.div_cnt = (st_ff.div_cnt == 7'h01) ? half
                                                : st_ff.div_cnt - 7'h01;
      if (sck_edge)
      begin
        nxt_st.sck = ~st_ff.sck;
      end
    end
    // Slave or idle master parks SCK at the polarity level
    if (!master || (st_ff.xfer == SPC_IDLE))
    begin
      nxt_st.sck = st_ff.ctl[CTL_CLOCK_POLARITY_BIT];
    end

    // Slave deselect drops any partial byte
    if (!master && ss_int_n)
    begin
      nxt_st.edge_cnt = 4'h0;
    end

    // Shifting: capture samples, the other edge presents next bit
    if (sck_edge)
    begin
      nxt_st.edge_cnt = st_ff.edge_cnt + 4'h1;
      if (capture)
      begin
        nxt_st.sh = {st_ff.sh[6:0], sin};
      end
      else
      begin
        nxt_st.dout = st_ff.sh[7];
      end
      if (st_ff.edge_cnt == LAST_EDGE)
      begin
        nxt_st.xfer     = SPC_IDLE;
        nxt_st.edge_cnt = 4'h0;
        nxt_st.done_ev  = 1'b1;
        nxt_st.done     = 1'b1;
        if (st_ff.done)
        begin
          nxt_st.overrun_flag = 1'b1;
        end
        else
        begin
          nxt_st.rxbuf = capture ? {st_ff.sh[6:0], sin}
                                 : st_ff.sh;
          // A status read from before this byte must not count
          nxt_st.stat_seen = 1'b0;
        end
      end
    end

    // Master mode fault: select driven low while master
    if (master && st_ff.ctl[CTL_PER_EN] && !ss_int_n)
    begin
      nxt_st.mode_fault_flag            = 1'b1;
      nxt_st.ctl[CTL_PER_EN] = 1'b0;
      nxt_st.ctl[CTL_MASTER] = 1'b0;
      nxt_st.xfer            = SPC_IDLE;
      nxt_st.edge_cnt        = 4'h0;
    end

    // Interrupt and wake outputs; collision is deliberately absent
    nxt_st.irq  = nxt_st.ctl[CTL_IRQ_EN] & ~cpu_irq_mask &
                  (nxt_st.done | nxt_st.mode_fault_flag | nxt_st.overrun_flag);
    nxt_st.wake = nxt_st.ctl[CTL_IRQ_EN] & nxt_st.done;

    // Pin enables, kept in the state so every output leaves a flop
    nxt_st.pins[3] = nxt_st.ctl[CTL_PER_EN];
    nxt_st.pins[2] = nxt_st.ctl[CTL_PER_EN] &
                     nxt_st.ctl[CTL_MASTER];
    nxt_st.pins[1] = nxt_st.pins[2] & ~nxt_st.stlo[STA_ODIS];
    nxt_st.pins[0] = nxt_st.ctl[CTL_PER_EN] & ~nxt_st.ctl[CTL_MASTER] &
                     ~nxt_st.stlo[STA_ODIS];
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_ff      <= '0;
      st_ff.ctl  <= SPC_CTRL_RST;
      st_ff.stlo <= SPC_STLO_RST;
      st_ff.xfer <= SPC_IDLE;
      st_ff.wreq <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata    = {24'h000000, st_ff.rdata};
  assign avs_waitrequest = st_ff.wreq;
  assign spi_irq         = st_ff.irq;
  assign halt_wake       = st_ff.wake;
  assign pins_alt_en     = st_ff.pins[3];
  assign sck_oe          = st_ff.pins[2];
  assign mosi_oe         = st_ff.pins[1];
  assign miso_oe         = st_ff.pins[0];
  assign sck_out         = st_ff.sck;
  assign mosi_out        = st_ff.dout;
  assign miso_out        = st_ff.dout;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_IRQ_GATE: assert property (spi_irq |-> ##0 !$past(cpu_irq_mask))
    else $error("irq raised while masked");
  AST_IRQ_SRC: assert property (
      (st_ff.done && st_ff.ctl[CTL_IRQ_EN] && !cpu_irq_mask)
      |=> spi_irq || !st_ff.done || !st_ff.ctl[CTL_IRQ_EN])
    else $error("done flag did not raise irq");
  AST_FAULT_CLR: assert property (
      (master && st_ff.ctl[CTL_PER_EN] && !ss_int_n)
      |=> st_ff.mode_fault_flag && !st_ff.ctl[CTL_PER_EN] && !st_ff.ctl[CTL_MASTER])
    else $error("mode fault did not drop enable and master");
  AST_IDLE_POL: assert property (
      (!master || (st_ff.xfer == SPC_IDLE))
      |=> sck_out == $past(st_ff.ctl[CTL_CLOCK_POLARITY_BIT]))
    else $error("sck idle level wrong");
  AST_INHIBIT: assert property (
      (wr_data && !busy && !sck_edge && st_ff.done && !st_ff.stat_seen)
      |=> $stable(st_ff.sh))
    else $error("data write not inhibited");
  AST_WRITE_COLLISION_FLAG: assert property (
      (wr_data && busy && !sck_edge) |=> st_ff.write_collision_flag && $stable(st_ff.sh))
    else $error("collision not flagged or write taken");
  AST_OVR_KEEP: assert property (
      (st_ff.done_ev && $past(st_ff.done))
      |-> st_ff.overrun_flag && $stable(st_ff.rxbuf))
    else $error("overrun overwrote buffer");
  AST_RSVD: assert property (rd_stat |-> avs_readdata[STA_RSVD] == 1'b0)
    else $error("reserved bit read nonzero");
  AST_BUS: assert property (
      (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

  COV_MASTER: cover property (master && st_ff.done_ev);
  COV_SLAVE: cover property (!master && st_ff.done_ev);
  COV_OVR: cover property ($rose(st_ff.overrun_flag));
  COV_MODE_FAULT_FLAG: cover property ($rose(st_ff.mode_fault_flag));

endmodule // spc_core

// ===== tb/spc_peer.sv
`timescale 1ns/1ps
// Far-side slave model, MSB first
module spc_peer (
  input  wire logic       sck,     // Line clock
  input  wire logic       mosi,    // Data from master
  input  wire logic       sel_n,   // Select, active low
  input  wire logic       clock_phase_bit,    // Phase shared with master
  input  wire logic [7:0] tx_byte, // Byte to return
  output logic            miso,    // Data to master
  output logic [7:0]      rx_byte  // Byte taken in
);
  logic [7:0] sh_ff;    // Outgoing copy
  int         edge_cnt; // Transitions in frame

  initial
  begin
    miso = 1'b0;
    rx_byte = 8'h00;
    edge_cnt = 0;
  end

  // Frame start; phase 0 shows first bit at once
  always @(negedge sel_n)
  begin
    sh_ff = tx_byte;
    edge_cnt = 0;
    if (!clock_phase_bit)
      miso = sh_ff[7];
  end

  // Released line inverts the last bit shown
  always @(posedge sel_n)
    miso = ~miso;

  // Capture on sampling edges, drive on the others
  always @(sck)
  begin
    if (!sel_n && edge_cnt < 16)
    begin
      if (edge_cnt[0] == clock_phase_bit)
        rx_byte = {rx_byte[6:0], mosi};
      else if (clock_phase_bit)
      begin
        miso = sh_ff[7];
        sh_ff = sh_ff << 1;
      end
      else
      begin
        sh_ff = sh_ff << 1;
        miso = sh_ff[7];
      end
      edge_cnt++;
    end
  end
endmodule // spc_peer

// ===== tb/spc_core_tb_top.sv
`timescale 1ns/1ps
module spc_core_tb_top;
  import spc_pkg::*;
  logic        core_clk, sys_rst, avs_read, avs_write;  // Clock, bus
  logic [7:0]  avs_address;                            // Byte address
  logic [31:0] avs_writedata, avs_readdata;            // Bus data
  logic        avs_waitrequest, cpu_irq_mask;          // Stall, mask
  logic        spi_irq, halt_wake, pins_alt_en;        // Status outs
  logic        sck_out, sck_oe, mosi_out, mosi_oe;     // Pin drives
  logic        miso_out, miso_oe, peer_miso;           // Pin drives
  logic        sck_drv, mosi_drv, ss_pin_n, peer_sel_n; // Bench pins
  logic        clock_phase_bit_r, sck_prev;                       // Mode, monitor
  logic [7:0]  peer_tx, peer_rx, rd;                   // Peer bytes
  logic [31:0] gap_cnt, gap_last;                      // SCK half
  int          err_total, n_compared;                  // Counters
  // Line levels: enabled driver wins, else bench level
  wire sck_w  = sck_oe ? sck_out : sck_drv;
  wire mosi_w = mosi_oe ? mosi_out : mosi_drv;
  wire miso_w = miso_oe ? miso_out : peer_miso;

  spc_core i_spc_core (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_irq_mask(cpu_irq_mask),
    .spi_irq(spi_irq), .halt_wake(halt_wake),
    .pins_alt_en(pins_alt_en), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n_in(ss_pin_n));

  spc_peer i_spc_peer (.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n),
    .clock_phase_bit(clock_phase_bit_r), .tx_byte(peer_tx), .miso(peer_miso),
    .rx_byte(peer_rx));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Half-period monitor: core edges between SCK toggles
  always @(posedge core_clk)
  begin
    gap_cnt <= gap_cnt + 1;
    sck_prev <= sck_out;
    if (sck_out !== sck_prev)
    begin
      gap_last <= gap_cnt;
      gap_cnt <= 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus access; bounded wait for waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50)
      err_total++;
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, e});
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (spi_irq !== 1'b1 && n < 4000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 4000)
      err_total++;
  endtask

  // Bench as master: mode 0, SCK high four core clocks, low eight
  task automatic slave_byte(input logic [7:0] b);
    ss_pin_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      repeat (4) @(posedge core_clk);
      mosi_drv <= b[i];
      repeat (4) @(posedge core_clk);
      sck_drv <= 1'b1;
      repeat (4) @(posedge core_clk);
      sck_drv <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    ss_pin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    test_done();
  end

  initial
  begin
    logic [2:0]  cd [6];
    logic [31:0] hp [6];
    logic [7:0]  ctl;
    cd = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
    hp = '{2, 4, 8, 16, 32, 64};
    {sys_rst, avs_read, avs_write, cpu_irq_mask} = 4'h8;
    {sck_drv, mosi_drv, ss_pin_n, peer_sel_n, clock_phase_bit_r} = 5'h06;
    {avs_address, avs_writedata, peer_tx} = '0;
    {gap_cnt, gap_last, sck_prev} = '0;
    err_total = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rchk(SPC_CTRL_ADDR, 8'h00);
    rchk(SPC_STAT_ADDR, 8'h00);
    bus(1'b1, SPC_STAT_ADDR, 8'hff);
    rchk(SPC_STAT_ADDR, 8'h07);
    rchk(8'h80, 8'h00);
    bus(1'b1, SPC_STAT_ADDR, 8'h03);
    // Master bytes over every divide ratio and clock mode
    for (int i = 0; i < 6; i++)
    begin
      ctl = {2'b11, cd[i][2], 1'b1, i[0], i[1], cd[i][1:0]};
      bus(1'b1, SPC_CTRL_ADDR, ctl & 8'hbf);
      sck_drv <= i[0];
      clock_phase_bit_r <= i[1];
      peer_tx <= 8'h96 + 8'(i);
      bus(1'b1, SPC_CTRL_ADDR, ctl);
      rchk(SPC_CTRL_ADDR, ctl);
      chk(sck_out, i[0]);
      chk({sck_oe, mosi_oe, pins_alt_en}, 3'h7);
      peer_sel_n <= 1'b0;
      bus(1'b1, SPC_DATA_ADDR, 8'h5a + 8'(i));
      wait_irq();
      chk(halt_wake, 1'b1);
      chk(gap_last, hp[i]);
      chk(sck_out, i[0]);
      rchk(SPC_STAT_ADDR, 8'h83);
      rchk(SPC_DATA_ADDR, 8'h96 + 8'(i));
      chk(peer_rx, 8'h5a + 8'(i));
      rchk(SPC_STAT_ADDR, 8'h03);
      peer_sel_n <= 1'b1;
    end
    // Collision mid-byte, then a data write while done is unread
    bus(1'b1, SPC_CTRL_ADDR, 8'h90);
    bus(1'b1, SPC_CTRL_ADDR, 8'hd0);
    {peer_tx, sck_drv, clock_phase_bit_r} <= {8'h77, 2'b00};
    peer_sel_n <= 1'b0;
    bus(1'b1, SPC_DATA_ADDR, 8'ha5);
    bus(1'b1, SPC_DATA_ADDR, 8'h3c);
    wait_irq();
    chk(peer_rx, 8'ha5);
    bus(1'b1, SPC_DATA_ADDR, 8'h11);
    repeat (40) @(posedge core_clk);
    chk({31'h0, gap_cnt > 32'd40}, 32'h1);
    rchk(SPC_STAT_ADDR, 8'hc3);
    rchk(SPC_DATA_ADDR, 8'h77);
    rchk(SPC_STAT_ADDR, 8'h03);
    peer_sel_n <= 1'b1;
    // Mode fault from the select pin, masked then unmasked
    cpu_irq_mask <= 1'b1;
    bus(1'b1, SPC_STAT_ADDR, 8'h00);
    ss_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(spi_irq, 1'b0);
    rchk(SPC_CTRL_ADDR, 8'h80);
    chk(pins_alt_en, 1'b0);
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({spi_irq, halt_wake}, 2'b10);
    ss_pin_n <= 1'b1;
    bus(1'b1, SPC_CTRL_ADDR, 8'h00);
    rchk(SPC_STAT_ADDR, 8'h10);
    bus(1'b1, SPC_CTRL_ADDR, 8'h00);
    rchk(SPC_STAT_ADDR, 8'h00);
    // Slave: two bytes without clearing done give overrun
    bus(1'b1, SPC_CTRL_ADDR, 8'hc3);
    chk({sck_oe, mosi_oe, miso_oe}, 3'h1);
    slave_byte(8'h5a);
    slave_byte(8'hc3);
    chk(spi_irq, 1'b1);
    rchk(SPC_STAT_ADDR, 8'ha0);
    rchk(SPC_DATA_ADDR, 8'h5a);
    rchk(SPC_STAT_ADDR, 8'h00);
    test_done();
  end
endmodule // spc_core_tb_top
